// ### pkg/dtc_pkg.sv
`default_nettype none
package dtc_pkg;
	// ------------------------------------------------------------
	// special function addresses
	// ------------------------------------------------------------
	localparam logic [7:0] DTC_ADDR_CONTROL = 8'h88;
	localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
	localparam logic [7:0] DTC_ADDR_LOW_ZERO = 8'h8A;
	localparam logic [7:0] DTC_ADDR_LOW_ONE = 8'h8B;
	localparam logic [7:0] DTC_ADDR_HIGH_ZERO = 8'h8C;
	localparam logic [7:0] DTC_ADDR_HIGH_ONE = 8'h8D;
	// bit addresses of the control register are base in bits 7:3 and bit number in bits 2:0
	localparam logic [4:0] DTC_CONTROL_BIT_BASE = 5'h11;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] DTC_RESET_CONTROL = 8'h00;
	localparam logic [7:0] DTC_RESET_MODE = 8'h00;
	localparam logic [7:0] DTC_RESET_COUNT = 8'h00;

	// ------------------------------------------------------------
	// control register fields
	// ------------------------------------------------------------
	localparam int DTC_CTL_OVF_ONE = 7;
	localparam int DTC_CTL_RUN_ONE = 6;
	localparam int DTC_CTL_OVF_ZERO = 5;
	localparam int DTC_CTL_RUN_ZERO = 4;

	// ------------------------------------------------------------
	// mode register fields
	// ------------------------------------------------------------
	localparam int DTC_MODE_GATE_ONE = 7;
	localparam int DTC_MODE_CT_ONE = 6;
	localparam int DTC_MODE_CODE_ONE_HI = 5;
	localparam int DTC_MODE_CODE_ONE_LO = 4;
	localparam int DTC_MODE_GATE_ZERO = 3;
	localparam int DTC_MODE_CT_ZERO = 2;
	localparam int DTC_MODE_CODE_ZERO_HI = 1;
	localparam int DTC_MODE_CODE_ZERO_LO = 0;

	// ------------------------------------------------------------
	// count field limits
	// ------------------------------------------------------------
	localparam logic [4:0] DTC_PRESCALE_MAX = 5'h1F;
	localparam logic [7:0] DTC_BYTE_MAX = 8'hFF;

	// encoding follows declaration order: 00, 01, 10, 11
	typedef enum logic [1:0] {
		DTC_MODE_13BIT,
		DTC_MODE_16BIT,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_e;
endpackage
`default_nettype wire

// ### rtl/dtc_timer_pair.sv
`default_nettype none
module dtc_timer_pair
	import dtc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic bit_wr,
	input wire logic [7:0] bit_addr,
	input wire logic bit_wdata,
	input wire logic vec_ack_zero,
	input wire logic vec_ack_one,
	input wire logic count_pin_zero,
	input wire logic count_pin_one,
	input wire logic ext_irq_pin_zero,
	input wire logic ext_irq_pin_one,
	output logic overflow_flag_zero,
	output logic overflow_flag_one
);
	import dtc_pkg::*;

	// ------------------------------------------------------------
	// step of one timer in modes 0..2, returns {ovf, high, low}
	// ------------------------------------------------------------
	function automatic logic [16:0] dtc_step(
		input dtc_mode_e mode,
		input logic [7:0] hi,
		input logic [7:0] lo,
		input logic tick
	);
		logic [7:0] h;
		logic [7:0] l;
		logic ovf;
		h = hi;
		l = lo;
		ovf = 1'b0;
		if (tick) begin
			unique case (mode)
				DTC_MODE_13BIT: begin
					// upper three low bits are left as they are and ignored
					l[4:0] = lo[4:0] + 5'h01;
					if (lo[4:0] == DTC_PRESCALE_MAX) begin
						h = hi + 8'h01;
						ovf = (hi == DTC_BYTE_MAX);
					end
				end
				DTC_MODE_16BIT: begin
					l = lo + 8'h01;
					if (lo == DTC_BYTE_MAX) begin
						h = hi + 8'h01;
						ovf = (hi == DTC_BYTE_MAX);
					end
				end
				DTC_MODE_RELOAD: begin
					if (lo == DTC_BYTE_MAX) begin
						l = hi;
						ovf = 1'b1;
					end else begin
						l = lo + 8'h01;
					end
				end
				DTC_MODE_SPLIT: begin
					h = hi;
					l = lo;
				end
			endcase
		end
		return {ovf, h, l};
	endfunction

	// ------------------------------------------------------------
	// pin synchronisers: {irq1, irq0, cnt1, cnt0}
	// ------------------------------------------------------------
	logic [3:0] meta_ff, nxt_meta;
	logic [3:0] sync_ff, nxt_sync;
	logic [1:0] prev_ff, nxt_prev;

	always_comb begin
		// two flops keep a metastable pin level away from the count and gate logic
		nxt_meta = {ext_irq_pin_one, ext_irq_pin_zero, count_pin_one, count_pin_zero};
		nxt_sync = meta_ff;
		// one more stage holds the previous sample for edge detection
		nxt_prev = sync_ff[1:0];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= 4'h0;
			sync_ff <= 4'h0;
			prev_ff <= 2'h0;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
			prev_ff <= nxt_prev;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [7:0] mode_ff, nxt_mode;
	logic [7:0] ctl_ff, nxt_ctl;
	logic [7:0] low_zero_ff, nxt_low_zero;
	logic [7:0] high_zero_ff, nxt_high_zero;
	logic [7:0] low_one_ff, nxt_low_one;
	logic [7:0] high_one_ff, nxt_high_one;
	logic [7:0] rdata_ff, nxt_rdata;

	// ------------------------------------------------------------
	// count enables
	// ------------------------------------------------------------
	logic [1:0] fall;
	logic gate_ok_zero;
	logic gate_ok_one;
	logic tick_zero;
	logic tick_one;
	logic tick_split_high;
	dtc_mode_e mode_zero;
	dtc_mode_e mode_one;

	always_comb begin
		// falling edge seen as high sample then low sample
		// a level shorter than one clock can slip between samples and be lost
		fall = prev_ff & ~sync_ff[1:0];
		mode_zero = dtc_mode_e'(mode_ff[DTC_MODE_CODE_ZERO_HI:DTC_MODE_CODE_ZERO_LO]);
		mode_one = dtc_mode_e'(mode_ff[DTC_MODE_CODE_ONE_HI:DTC_MODE_CODE_ONE_LO]);
		gate_ok_zero = ctl_ff[DTC_CTL_RUN_ZERO]
			& (~mode_ff[DTC_MODE_GATE_ZERO] | sync_ff[2]);
		gate_ok_one = ctl_ff[DTC_CTL_RUN_ONE]
			& (~mode_ff[DTC_MODE_GATE_ONE] | sync_ff[3]);
		tick_zero = gate_ok_zero & (mode_ff[DTC_MODE_CT_ZERO] ? fall[0] : 1'b1);
		tick_one = gate_ok_one & (mode_ff[DTC_MODE_CT_ONE] ? fall[1] : 1'b1);
		// split high byte is a plain timer on the timer one run bit
		tick_split_high = ctl_ff[DTC_CTL_RUN_ONE];
	end

	// ------------------------------------------------------------
	// counting and register writes
	// ------------------------------------------------------------
	logic [16:0] step_zero;
	logic [16:0] step_one;
	logic ovf_zero;
	logic ovf_one;
	logic bit_hit;
	logic [2:0] bit_idx;

	always_comb begin
		step_zero = dtc_step(mode_zero, high_zero_ff, low_zero_ff, tick_zero);
		step_one = dtc_step(mode_one, high_one_ff, low_one_ff, tick_one);
		nxt_low_zero = step_zero[7:0];
		nxt_high_zero = step_zero[15:8];
		ovf_zero = step_zero[16];
		nxt_low_one = step_one[7:0];
		nxt_high_one = step_one[15:8];
		ovf_one = step_one[16];
		if (mode_zero == DTC_MODE_SPLIT) begin
			// two independent 8-bit counters, high one borrows timer one flag
			nxt_low_zero = low_zero_ff + {7'h00, tick_zero};
			ovf_zero = tick_zero & (low_zero_ff == DTC_BYTE_MAX);
			nxt_high_zero = high_zero_ff + {7'h00, tick_split_high};
			// timer one keeps counting but no longer owns its flag
			ovf_one = tick_split_high & (high_zero_ff == DTC_BYTE_MAX);
		end
		if (mode_one == DTC_MODE_SPLIT) begin
			// timer one stopped: counts hold
			nxt_low_one = low_one_ff;
			nxt_high_one = high_one_ff;
			if (mode_zero != DTC_MODE_SPLIT) begin
				ovf_one = 1'b0;
			end
		end

		// a software byte write to a count register wins over counting
		nxt_mode = mode_ff;
		nxt_ctl = ctl_ff;
		if (sfr_wr) begin
			unique case (sfr_addr)
				DTC_ADDR_MODE: nxt_mode = sfr_wdata;
				DTC_ADDR_CONTROL: nxt_ctl = sfr_wdata;
				DTC_ADDR_LOW_ZERO: nxt_low_zero = sfr_wdata;
				DTC_ADDR_HIGH_ZERO: nxt_high_zero = sfr_wdata;
				DTC_ADDR_LOW_ONE: nxt_low_one = sfr_wdata;
				DTC_ADDR_HIGH_ONE: nxt_high_one = sfr_wdata;
				default: ;
			endcase
		end
		// bit writes land after byte writes, so a bit write wins for its bit
		// only the control register answers bit writes; mode is byte only
		bit_hit = bit_wr && (bit_addr[7:3] == DTC_CONTROL_BIT_BASE);
		bit_idx = bit_addr[2:0];
		if (bit_hit) begin
			nxt_ctl[bit_idx] = bit_wdata;
		end

		// vector acknowledge clears, a same-cycle overflow still sets
		if (vec_ack_zero) begin
			nxt_ctl[DTC_CTL_OVF_ZERO] = 1'b0;
		end
		if (vec_ack_one) begin
			nxt_ctl[DTC_CTL_OVF_ONE] = 1'b0;
		end
		if (ovf_zero) begin
			nxt_ctl[DTC_CTL_OVF_ZERO] = 1'b1;
		end
		if (ovf_one) begin
			nxt_ctl[DTC_CTL_OVF_ONE] = 1'b1;
		end
		// run bits only gate the tick; counts are never cleared here
	end

	// ------------------------------------------------------------
	// read port, registered one cycle after the read strobe
	// ------------------------------------------------------------
	always_comb begin
		// unmapped addresses read 00, never a stale byte
		nxt_rdata = rdata_ff;
		if (sfr_rd) begin
			unique case (sfr_addr)
				DTC_ADDR_MODE: nxt_rdata = mode_ff;
				DTC_ADDR_CONTROL: nxt_rdata = ctl_ff;
				DTC_ADDR_LOW_ZERO: nxt_rdata = low_zero_ff;
				DTC_ADDR_HIGH_ZERO: nxt_rdata = high_zero_ff;
				DTC_ADDR_LOW_ONE: nxt_rdata = low_one_ff;
				DTC_ADDR_HIGH_ONE: nxt_rdata = high_one_ff;
				default: nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------
	// register state: configuration and counts
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_ff <= DTC_RESET_MODE;
			ctl_ff <= DTC_RESET_CONTROL;
		end else begin
			mode_ff <= nxt_mode;
			ctl_ff <= nxt_ctl;
		end
	end

	// counts keep their value across any run bit change
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			low_zero_ff <= DTC_RESET_COUNT;
			high_zero_ff <= DTC_RESET_COUNT;
			low_one_ff <= DTC_RESET_COUNT;
			high_one_ff <= DTC_RESET_COUNT;
		end else begin
			low_zero_ff <= nxt_low_zero;
			high_zero_ff <= nxt_high_zero;
			low_one_ff <= nxt_low_one;
			high_one_ff <= nxt_high_one;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// flags come straight from the control register, so a read and the pins agree
	assign sfr_rdata = rdata_ff;
	assign overflow_flag_zero = ctl_ff[DTC_CTL_OVF_ZERO];
	assign overflow_flag_one = ctl_ff[DTC_CTL_OVF_ONE];
endmodule
`default_nettype wire

// ### bench/dtc_timer_pair_monitor.sv
`default_nettype none
module dtc_timer_pair_monitor
	import dtc_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic bit_wr,
	input wire logic [7:0] bit_addr,
	input wire logic bit_wdata,
	input wire logic vec_ack_zero,
	input wire logic vec_ack_one,
	input wire logic count_pin_zero,
	input wire logic count_pin_one,
	input wire logic ext_irq_pin_zero,
	input wire logic ext_irq_pin_one,
	input wire logic overflow_flag_zero,
	input wire logic overflow_flag_one
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic hole;
	assign hole = sfr_addr < DTC_ADDR_CONTROL || sfr_addr > DTC_ADDR_HIGH_ONE;
	// ----------------------------------------
	// register port
	// ----------------------------------------
	rd_hole_a: assert property (sfr_rd && hole |=> sfr_rdata == 8'h00)
		else $error("read of a hole not zero");
	rd_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata))
		else $error("read data moved without a read");
	rd_flag_a: assert property (sfr_rd && sfr_addr == DTC_ADDR_CONTROL |=>
		sfr_rdata[7] == $past(overflow_flag_one) && sfr_rdata[5] == $past(overflow_flag_zero))
		else $error("control read disagrees with flags");
	mode_back_a: assert property (sfr_wr && sfr_addr == DTC_ADDR_MODE ##2
		sfr_rd && sfr_addr == DTC_ADDR_MODE |=> sfr_rdata == $past(sfr_wdata, 3))
		else $error("mode read differs from write");
	// ----------------------------------------
	// flags: software may set, only ack or write clears
	// ----------------------------------------
	bit_set_a: assert property (bit_wr && bit_addr == 8'h8D && bit_wdata |=> overflow_flag_zero)
		else $error("bit write did not set flag zero");
	byte_set_a: assert property (sfr_wr && sfr_addr == DTC_ADDR_CONTROL && sfr_wdata[7]
		&& !bit_wr |=> overflow_flag_one)
		else $error("byte write did not set flag one");
	fall_zero_a: assert property ($fell(overflow_flag_zero) |-> $past(vec_ack_zero || sfr_wr || bit_wr))
		else $error("flag zero dropped without cause");
	fall_one_a: assert property ($fell(overflow_flag_one) |-> $past(vec_ack_one || sfr_wr || bit_wr))
		else $error("flag one dropped without cause");
	cover property (vec_ack_zero && overflow_flag_zero);
	cover property ($rose(overflow_flag_one));
	cover property (sfr_rd && sfr_addr == DTC_ADDR_MODE);
endmodule
bind dtc_timer_pair dtc_timer_pair_monitor u_mon (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
	.bit_wr(bit_wr), .bit_addr(bit_addr), .bit_wdata(bit_wdata), .vec_ack_zero(vec_ack_zero),
	.vec_ack_one(vec_ack_one), .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
	.ext_irq_pin_zero(ext_irq_pin_zero), .ext_irq_pin_one(ext_irq_pin_one),
	.overflow_flag_zero(overflow_flag_zero), .overflow_flag_one(overflow_flag_one));
`default_nettype wire

// ### bench/dtc_pin_model.sv
`default_nettype none
module dtc_pin_model (
	input wire logic clk,
	output logic pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// pin idles high, as the port pull-up would leave it
	initial pin = 1'b1;
	// each level stands hold cycles, at least one, so every level is sampled
	task automatic pulse(input int n, input int hold);
		repeat (n) begin
			@(negedge clk) pin = 1'b0;
			repeat (hold - 1) @(negedge clk);
			@(negedge clk) pin = 1'b1;
			repeat (hold - 1) @(negedge clk);
		end
	endtask
endmodule
`default_nettype wire

// ### bench/dtc_timer_pair_tb.sv
`default_nettype none
module dtc_timer_pair_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dtc_pkg::*;
	logic clk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, bit_wr = 0, bit_wdata = 0;
	logic vack0 = 0, vack1 = 0, gate0 = 1, gate1 = 1, rd_seen = 0;
	logic [7:0] addr = 0, wdata = 0, baddr = 0, rdata, e;
	logic [7:0] map[7] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E};
	logic [7:0] exp_q[$];
	wire logic pin0, pin1, flag0, flag1;
	int n_fail = 0, n_checks = 0, cyc = 0;
	always #2 clk = ~clk;
	dtc_timer_pair u_dtc_timer_pair (.clk(clk), .rst_n(rst_n), .sfr_addr(addr),
		.sfr_wr(sfr_wr), .sfr_wdata(wdata), .sfr_rd(sfr_rd), .sfr_rdata(rdata), .bit_wr(bit_wr),
		.bit_addr(baddr), .bit_wdata(bit_wdata), .vec_ack_zero(vack0), .vec_ack_one(vack1),
		.count_pin_zero(pin0), .count_pin_one(pin1), .ext_irq_pin_zero(gate0),
		.ext_irq_pin_one(gate1), .overflow_flag_zero(flag0), .overflow_flag_one(flag1));
	dtc_pin_model pin_zero (.clk(clk), .pin(pin0));
	dtc_pin_model pin_one (.clk(clk), .pin(pin1));
	// ----------------------------------------
	// bus tasks and result watcher
	// ----------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	always @(posedge clk) rd_seen <= sfr_rd;
	always @(negedge clk) if (rd_seen) chk(rdata, exp_q.pop_front());
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk) {sfr_wr, addr, wdata} = {1'b1, a, d};
		@(negedge clk) sfr_wr = 0;
	endtask
	task automatic bw(input logic [7:0] a, input logic b);
		@(negedge clk) {bit_wr, baddr, bit_wdata} = {1'b1, a, b};
		@(negedge clk) bit_wr = 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(negedge clk) {sfr_rd, addr} = {1'b1, a};
		exp_q.push_back(x);
		@(negedge clk) sfr_rd = 0;
	endtask
	task automatic ack(input logic one);
		@(negedge clk) {vack1, vack0} = {one, !one};
		@(negedge clk) {vack1, vack0} = 2'b00;
	endtask
	task automatic done(input int t);
		repeat (3) @(negedge clk);
		$display("test %0d finished", t);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// a hang ends the run as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			summarize();
		end
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		void'($urandom(32'hf6b5_4a49));
		repeat (8) @(negedge clk);
		rst_n = 1;
		foreach (map[i]) rd(map[i], 8'h00);
		done(1);
		e = 8'($urandom) & 8'hEE;
		wr(DTC_ADDR_MODE, e);
		rd(DTC_ADDR_MODE, e);
		bw(8'h90, 1'b1);
		bw(8'h8D, 1'b1);
		rd(DTC_ADDR_CONTROL, 8'h20);
		ack(1'b0);
		wr(DTC_ADDR_CONTROL, 8'h80);
		rd(DTC_ADDR_CONTROL, 8'h80);
		ack(1'b1);
		rd(DTC_ADDR_CONTROL, 8'h00);
		done(2);
		wr(DTC_ADDR_MODE, 8'h01);
		wr(DTC_ADDR_LOW_ZERO, 8'hFE);
		wr(DTC_ADDR_HIGH_ZERO, 8'hFF);
		bw(8'h8C, 1'b1);
		repeat (8) @(negedge clk);
		bw(8'h8C, 1'b0);
		rd(DTC_ADDR_CONTROL, 8'h20);
		rd(DTC_ADDR_LOW_ZERO, 8'h08);
		rd(DTC_ADDR_HIGH_ZERO, 8'h00);
		ack(1'b0);
		done(3);
		// slow edges, then the fastest legal rate
		wr(DTC_ADDR_MODE, 8'h50);
		bw(8'h8E, 1'b1);
		pin_one.pulse(5, 3);
		pin_one.pulse(4, 1);
		repeat (8) @(negedge clk);
		bw(8'h8E, 1'b0);
		rd(DTC_ADDR_LOW_ONE, 8'h09);
		done(4);
		// edges while the gate pin is low must not count
		wr(DTC_ADDR_MODE, 8'h0E);
		wr(DTC_ADDR_HIGH_ZERO, 8'hF0);
		wr(DTC_ADDR_LOW_ZERO, 8'hFE);
		bw(8'h8C, 1'b1);
		pin_zero.pulse(3, 2);
		repeat (8) @(negedge clk);
		gate0 = 0;
		pin_zero.pulse(2, 2);
		repeat (8) @(negedge clk);
		bw(8'h8C, 1'b0);
		rd(DTC_ADDR_LOW_ZERO, 8'hF1);
		rd(DTC_ADDR_HIGH_ZERO, 8'hF0);
		rd(DTC_ADDR_CONTROL, 8'h20);
		ack(1'b0);
		done(5);
		e = {3'($urandom), 5'h1E};
		wr(DTC_ADDR_MODE, 8'h04);
		wr(DTC_ADDR_LOW_ZERO, e);
		wr(DTC_ADDR_HIGH_ZERO, 8'hFF);
		bw(8'h8C, 1'b1);
		pin_zero.pulse(2, 1);
		repeat (8) @(negedge clk);
		bw(8'h8C, 1'b0);
		rd(DTC_ADDR_LOW_ZERO, {e[7:5], 5'h00});
		rd(DTC_ADDR_CONTROL, 8'h20);
		done(6);
		wr(DTC_ADDR_MODE, 8'h30);
		wr(DTC_ADDR_LOW_ONE, 8'h33);
		bw(8'h8E, 1'b1);
		repeat (8) @(negedge clk);
		rd(DTC_ADDR_LOW_ONE, 8'h33);
		done(7);
		// split mode: low zero on timer zero controls, high zero on run bit one
		wr(DTC_ADDR_CONTROL, 8'h00);
		wr(DTC_ADDR_MODE, 8'h03);
		wr(DTC_ADDR_LOW_ZERO, 8'hFD);
		wr(DTC_ADDR_HIGH_ZERO, 8'hFE);
		wr(DTC_ADDR_CONTROL, 8'h50);
		repeat (4) @(negedge clk);
		bw(8'h8C, 1'b0);
		bw(8'h8E, 1'b0);
		rd(DTC_ADDR_LOW_ZERO, 8'h03);
		rd(DTC_ADDR_HIGH_ZERO, 8'h06);
		rd(DTC_ADDR_LOW_ONE, 8'h3B);
		rd(DTC_ADDR_CONTROL, 8'hA0);
		chk({6'h00, flag1, flag0}, 8'h03);
		ack(1'b1);
		rd(DTC_ADDR_CONTROL, 8'h20);
		done(8);
		// with its gate bit set, timer one waits for its gate pin
		gate1 = 0;
		wr(DTC_ADDR_MODE, 8'h80);
		wr(DTC_ADDR_CONTROL, 8'h40);
		repeat (8) @(negedge clk);
		wr(DTC_ADDR_CONTROL, 8'h00);
		rd(DTC_ADDR_LOW_ONE, 8'h3B);
		gate1 = 1;
		wr(DTC_ADDR_CONTROL, 8'h40);
		wr(DTC_ADDR_CONTROL, 8'h00);
		rd(DTC_ADDR_LOW_ONE, 8'h3D);
		done(9);
		summarize();
	end
endmodule
`default_nettype wire
